// ---- hdl/scpb_top.sv ----
// serial pin port override and two-channel bit-rate generation
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module scpb_top
    import scpb_pkg::*;
(
    input  wire logic                    ref_clk_i,
    input  wire logic                    srst_i,
    input  wire logic                    standby_i,
    input  wire logic                    module_standby_i,
    // axi4-lite slave
    input  wire logic [AXI_ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [AXI_DATA_W-1:0]   s_axi_wdata,
    input  wire logic [AXI_DATA_W/8-1:0] s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [AXI_ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [AXI_DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    // serial pins of channel 0
    input  wire logic                    sck_i,
    output logic                         sck_o,
    output logic                         sck_oe_o,
    output logic                         txd_o,
    output logic                         txd_oe_o,
    input  wire logic                    rxd_i,
    // bit-rate ticks, one per channel
    output logic [1:0]                   bit_tick_o
);

    // ---------------- bus group ----------------
    logic                  awready_reg;
    logic                  awready_next;
    logic                  wready_reg;
    logic                  wready_next;
    logic                  aw_got_reg;
    logic                  aw_got_next;
    logic                  w_got_reg;
    logic                  w_got_next;
    logic [AXI_ADDR_W-1:0] waddr_reg;
    logic [AXI_ADDR_W-1:0] waddr_next;
    logic [AXI_DATA_W-1:0] wdata_reg;
    logic [AXI_DATA_W-1:0] wdata_next;
    logic [3:0]            wstrb_reg;
    logic [3:0]            wstrb_next;
    logic                  bvalid_reg;
    logic                  bvalid_next;
    logic [1:0]            bresp_reg;
    logic [1:0]            bresp_next;
    logic                  arready_reg;
    logic                  arready_next;
    logic                  rvalid_reg;
    logic                  rvalid_next;
    logic [AXI_DATA_W-1:0] rdata_reg;
    logic [AXI_DATA_W-1:0] rdata_next;
    logic [1:0]            rresp_reg;
    logic [1:0]            rresp_next;

    // write strobe toward the register group
    logic                  do_write;
    logic [AXI_ADDR_W-1:0] wr_addr;
    logic [AXI_DATA_W-1:0] wr_data;
    logic [3:0]            wr_strb;

    // ---------------- register group ----------------
    scpb_pin_ctl_type      pin_ctl_reg;
    scpb_pin_ctl_type      pin_ctl_next;
    logic [PD_WIDTH-1:0]   pin_data_reg;
    logic [PD_WIDTH-1:0]   pin_data_next;
    logic [DIV_WIDTH-1:0]  divisor_reg [2];
    logic [DIV_WIDTH-1:0]  divisor_next [2];
    scpb_chan_cfg_type     cfg_reg [2];
    scpb_chan_cfg_type     cfg_next [2];

    // ---------------- pin group ----------------
    logic                  sck_s1_reg;
    logic                  sck_s2_reg;
    logic                  rxd_s1_reg;
    logic                  rxd_s2_reg;
    scpb_pin_drv_type      sck_drv_reg;
    scpb_pin_drv_type      sck_drv_next;
    scpb_pin_drv_type      txd_drv_reg;
    scpb_pin_drv_type      txd_drv_next;

    logic [1:0]            tick;
    logic                  standby_clear;

    assign standby_clear = standby_i || module_standby_i;

    function automatic logic ok_addr(input logic [AXI_ADDR_W-1:0] a);
        return (a == OFS_PIN_CONTROL) || (a == OFS_PIN_DATA)
            || (a == OFS_DIVISOR_0)   || (a == OFS_DIVISOR_1)
            || (a == OFS_CHAN_CFG_0)  || (a == OFS_CHAN_CFG_1)
            || (a == OFS_STATUS);
    endfunction

    // merge one byte lane of a write into a narrow register
    function automatic logic [7:0] lane0(input logic [7:0] old,
                                         input logic [7:0] d,
                                         input logic [3:0] s);
        return s[0] ? d : old;
    endfunction

    // ---------------- bus: next state ----------------
    always_comb begin
        logic aw_hs;
        logic w_hs;
        logic ar_hs;
        aw_hs        = s_axi_awvalid && awready_reg;
        w_hs         = s_axi_wvalid && wready_reg;
        ar_hs        = s_axi_arvalid && arready_reg;
        aw_got_next  = aw_got_reg || aw_hs;
        w_got_next   = w_got_reg || w_hs;
        waddr_next   = aw_hs ? s_axi_awaddr : waddr_reg;
        wdata_next   = w_hs ? s_axi_wdata : wdata_reg;
        wstrb_next   = w_hs ? s_axi_wstrb : wstrb_reg;
        bvalid_next  = bvalid_reg && !s_axi_bready;
        bresp_next   = bresp_reg;
        do_write     = 1'b0;
        wr_addr      = waddr_next;
        wr_data      = wdata_next;
        wr_strb      = wstrb_next;
        if (aw_got_next && w_got_next && !bvalid_next) begin
            do_write    = 1'b1;
            bvalid_next = 1'b1;
            bresp_next  = ok_addr(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            aw_got_next = 1'b0;
            w_got_next  = 1'b0;
        end
        awready_next = !aw_got_next && !bvalid_next;
        wready_next  = !w_got_next && !bvalid_next;

        rvalid_next  = rvalid_reg && !s_axi_rready;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (ar_hs) begin
            rvalid_next = 1'b1;
            rresp_next  = ok_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata_next  = '0;
            unique case (s_axi_araddr)
                OFS_PIN_CONTROL: rdata_next[PC_WIDTH-1:0] = pin_ctl_reg;
                OFS_PIN_DATA: begin
                    rdata_next[PD_WIDTH-1:0] = pin_data_reg;
                    // receive pin shows through whatever break mode says
                    if (cfg_reg[0].rx_enable_bit) begin
                        rdata_next[PD_BRK_BIT] = rxd_s2_reg;
                    end
                end
                OFS_DIVISOR_0: rdata_next[DIV_WIDTH-1:0] = divisor_reg[0];
                OFS_DIVISOR_1: rdata_next[DIV_WIDTH-1:0] = divisor_reg[1];
                OFS_CHAN_CFG_0: rdata_next[CFG_WIDTH-1:0] = cfg_reg[0];
                OFS_CHAN_CFG_1: rdata_next[CFG_WIDTH-1:0] = cfg_reg[1];
                OFS_STATUS: rdata_next[3:0] = {sck_drv_reg.oe,
                                               txd_drv_reg.oe,
                                               sck_s2_reg,
                                               rxd_s2_reg};
                default: rdata_next = '0;
            endcase
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            aw_got_reg  <= 1'b0;
            w_got_reg   <= 1'b0;
            waddr_reg   <= '0;
            wdata_reg   <= '0;
            wstrb_reg   <= '0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= RESP_OKAY;
        end else begin
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            aw_got_reg  <= aw_got_next;
            w_got_reg   <= w_got_next;
            waddr_reg   <= waddr_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
        end
    end

    // ---------------- registers: next state ----------------
    always_comb begin
        logic [7:0] b0;
        b0            = wr_data[7:0];
        pin_ctl_next  = pin_ctl_reg;
        pin_data_next = pin_data_reg;
        for (int c = 0; c < 2; c++) begin
            divisor_next[c] = divisor_reg[c];
            cfg_next[c]     = cfg_reg[c];
        end
        if (do_write && wr_strb[0]) begin
            unique case (wr_addr)
                OFS_PIN_CONTROL: pin_ctl_next = b0[PC_WIDTH-1:0];
                OFS_PIN_DATA:    pin_data_next = b0[PD_WIDTH-1:0];
                OFS_DIVISOR_0:   divisor_next[0] = lane0(divisor_reg[0],
                                                         b0, wr_strb);
                OFS_DIVISOR_1:   divisor_next[1] = lane0(divisor_reg[1],
                                                         b0, wr_strb);
                OFS_CHAN_CFG_0:  cfg_next[0] = b0[CFG_WIDTH-1:0];
                OFS_CHAN_CFG_1:  cfg_next[1] = b0[CFG_WIDTH-1:0];
                default: ;
            endcase
        end
        // input modes 10 and 11 follow the pin; a write there is overrun
        if (pin_ctl_reg.clock_pin_mode[1]) begin
            pin_data_next[PD_CLK_BIT] = sck_s2_reg;
        end
        // standby wins over a divisor write in the same cycle
        if (standby_clear) begin
            divisor_next[0] = DIVISOR_RESET;
            divisor_next[1] = DIVISOR_RESET;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pin_ctl_reg  <= PIN_CONTROL_RESET;
            // break data bit has no defined reset value; zero is one choice
            pin_data_reg <= PIN_DATA_RESET;
            for (int c = 0; c < 2; c++) begin
                divisor_reg[c] <= DIVISOR_RESET;
                cfg_reg[c]     <= CHAN_CFG_RESET;
            end
        end else begin
            pin_ctl_reg  <= pin_ctl_next;
            pin_data_reg <= pin_data_next;
            for (int c = 0; c < 2; c++) begin
                divisor_reg[c] <= divisor_next[c];
                cfg_reg[c]     <= cfg_next[c];
            end
        end
    end

    // ---------------- pins: next state ----------------
    always_comb begin
        // only mode 01 drives; 00, 10, 11 leave the pin free
        sck_drv_next.oe = pin_ctl_reg.clock_pin_mode
                          == CLK_MODE_OUT;
        sck_drv_next.o  = pin_data_reg[PD_CLK_BIT];
        // break codes 10 and 11 treated as 00
        txd_drv_next.oe = pin_ctl_reg.break_pin_mode
                          == BRK_MODE_OUT;
        txd_drv_next.o  = pin_data_reg[PD_BRK_BIT];
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            sck_s1_reg  <= 1'b0;
            sck_s2_reg  <= 1'b0;
            rxd_s1_reg  <= 1'b1;
            rxd_s2_reg  <= 1'b1;
            sck_drv_reg <= '0;
            txd_drv_reg <= '0;
        end else begin
            sck_s1_reg  <= sck_i;
            sck_s2_reg  <= sck_s1_reg;
            rxd_s1_reg  <= rxd_i;
            rxd_s2_reg  <= rxd_s1_reg;
            sck_drv_reg <= sck_drv_next;
            txd_drv_reg <= txd_drv_next;
        end
    end

    // ---------------- rate generators ----------------
    // a channel's generator runs only while it transmits or receives
    for (genvar c = 0; c < 2; c++) begin : g_rate
        scpb_rate_gen u_rate (
            .ref_clk_i   (ref_clk_i),
            .srst_i      (srst_i || standby_clear),
            .run_i       (cfg_reg[c].tx_enable_bit
                          || cfg_reg[c].rx_enable_bit),
            .sync_mode_i (cfg_reg[c].sync_mode),
            .prescale_i  (cfg_reg[c].prescale_select),
            .divisor_i   (divisor_reg[c]),
            .tick_o      (tick[c])
        );
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign sck_o         = sck_drv_reg.o;
    assign sck_oe_o      = sck_drv_reg.oe;
    assign txd_o         = txd_drv_reg.o;
    assign txd_oe_o      = txd_drv_reg.oe;
    assign bit_tick_o    = tick;

endmodule

// ---- hdl/scpb_pkg.sv ----
// package: constants, types and register map for the serial port block
// Notes on behaviour
// - only pin control bits 3:0 and pin data bits 1:0 act on serial pins
// - clock-pin mode 00 no drive, 01 drive data bit 1, 10 capture pin level
// - clock-pin output mode drives the pin with data bit 1, 0 low, 1 high
// - break mode 00 (reset) keeps bit 0 off; 01 drives it on transmit pin
// - transmit-pin output mode drives the pin with data bit 0
// - with channel 0 receive enable set, data bit 0 reads the receive pin level
// - data bit 0 has no defined value after power-on reset
// - 8-bit divisor with two-bit prescale select sets the bit rate
// - divisor always read/write; reset, standby, module standby load FF
// - two channels, each with its own divisor and rate generator
// - period is (N+1)*64*2^(2n-1) async, (N+1)*8*2^(2n-1) sync clocks
// - prescale select 00 clock, 01 /4, 10 /16, 11 /64
// - every divisor value from 0 to 255 is honoured
package scpb_pkg;

    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;

    // register byte addresses
    localparam logic [7:0] OFS_PIN_CONTROL = 8'h00;
    localparam logic [7:0] OFS_PIN_DATA    = 8'h04;
    localparam logic [7:0] OFS_DIVISOR_0   = 8'h08;
    localparam logic [7:0] OFS_DIVISOR_1   = 8'h0C;
    localparam logic [7:0] OFS_CHAN_CFG_0  = 8'h10;
    localparam logic [7:0] OFS_CHAN_CFG_1  = 8'h14;
    localparam logic [7:0] OFS_STATUS      = 8'h18;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // pin control and data layout
    localparam int PC_WIDTH      = 4;
    localparam int PD_WIDTH      = 2;
    localparam int PD_CLK_BIT    = 1;
    localparam int PD_BRK_BIT    = 0;
    localparam logic [3:0] PIN_CONTROL_RESET = 4'h8;
    localparam logic [1:0] PIN_DATA_RESET    = 2'h0;

    // clock-pin and break-pin mode codes
    localparam logic [1:0] CLK_MODE_OFF = 2'h0;
    localparam logic [1:0] CLK_MODE_OUT = 2'h1;
    localparam logic [1:0] BRK_MODE_OUT = 2'h1;

    // divisor
    localparam int DIV_WIDTH = 8;
    localparam logic [7:0] DIVISOR_RESET = 8'hFF;

    // channel configuration layout
    localparam int CFG_PRESCALE_LO = 0;
    localparam int CFG_SYNC_BIT    = 2;
    localparam int CFG_TX_EN_BIT   = 3;
    localparam int CFG_RX_EN_BIT   = 4;
    localparam int CFG_CKSRC_LO    = 5;
    localparam int CFG_WIDTH       = 7;
    localparam logic [6:0] CHAN_CFG_RESET = 7'h00;

    // rate generator factors: 2^(2n-1) = 4^n / 2
    localparam int ASYNC_FACTOR = 64;
    localparam int SYNC_FACTOR  = 8;
    localparam int BASE_W       = 5;
    localparam logic [4:0] ASYNC_BASE_LAST = 5'(ASYNC_FACTOR / 2 - 1);
    localparam logic [4:0] SYNC_BASE_LAST  = 5'(SYNC_FACTOR / 2 - 1);
    localparam int PRE_W = 6;
    localparam logic [5:0] PRE_LAST_0 = 6'h00;
    localparam logic [5:0] PRE_LAST_1 = 6'h03;
    localparam logic [5:0] PRE_LAST_2 = 6'h0F;
    localparam logic [5:0] PRE_LAST_3 = 6'h3F;

    typedef struct packed {
        logic [1:0] clock_pin_source;
        logic       rx_enable_bit;
        logic       tx_enable_bit;
        logic       sync_mode;
        logic [1:0] prescale_select;
    } scpb_chan_cfg_type;

    typedef struct packed {
        logic [1:0] clock_pin_mode;
        logic [1:0] break_pin_mode;
    } scpb_pin_ctl_type;

    typedef struct packed {
        logic o;
        logic oe;
    } scpb_pin_drv_type;

endpackage

// ---- hdl/scpb_rate_gen.sv ----
// one channel's bit-rate generator: prescaler, base divider, divisor
`timescale 1ns/1ns
module scpb_rate_gen
    import scpb_pkg::*;
(
    input  wire logic                 ref_clk_i,
    input  wire logic                 srst_i,
    input  wire logic                 run_i,
    input  wire logic                 sync_mode_i,
    input  wire logic [1:0]           prescale_i,
    input  wire logic [DIV_WIDTH-1:0] divisor_i,
    output logic                      tick_o
);

    logic [PRE_W-1:0]     pre_reg;
    logic [PRE_W-1:0]     pre_next;
    logic [BASE_W-1:0]    base_reg;
    logic [BASE_W-1:0]    base_next;
    logic [DIV_WIDTH-1:0] div_reg;
    logic [DIV_WIDTH-1:0] div_next;
    logic                 tick_reg;
    logic                 tick_next;

    function automatic logic [PRE_W-1:0] pre_last(input logic [1:0] sel);
        logic [PRE_W-1:0] r;
        r = PRE_LAST_0;
        unique case (sel)
            2'h0: r = PRE_LAST_0;
            2'h1: r = PRE_LAST_1;
            2'h2: r = PRE_LAST_2;
            2'h3: r = PRE_LAST_3;
        endcase
        return r;
    endfunction

    always_comb begin
        logic             pre_wrap;
        logic             base_wrap;
        logic [BASE_W-1:0] base_last;
        // >= so a setting lowered mid-count still wraps at once
        base_last = sync_mode_i ? SYNC_BASE_LAST : ASYNC_BASE_LAST;
        pre_wrap  = pre_reg >= pre_last(prescale_i);
        base_wrap = pre_wrap && (base_reg >= base_last);
        pre_next  = pre_wrap ? '0 : pre_reg + 1'b1;
        base_next = base_reg;
        div_next  = div_reg;
        tick_next = 1'b0;
        if (pre_wrap) begin
            base_next = base_wrap ? '0 : base_reg + 1'b1;
        end
        if (base_wrap) begin
            // N+1 base periods per bit, N from 0 to 255
            if (div_reg >= divisor_i) begin
                div_next  = '0;
                tick_next = 1'b1;
            end else begin
                div_next = div_reg + 1'b1;
            end
        end
        if (!run_i) begin
            pre_next  = '0;
            base_next = '0;
            div_next  = '0;
            tick_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pre_reg  <= '0;
            base_reg <= '0;
            div_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            pre_reg  <= pre_next;
            base_reg <= base_next;
            div_reg  <= div_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_o = tick_reg;

endmodule

// ---- bench/scpb_checker.sv ----
// port-level assertions for the serial port block
`timescale 1ns/1ns
module scpb_checker
    import scpb_pkg::*;
(
    input wire logic                  ref_clk_i,
    input wire logic                  srst_i,
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_wready,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_bready,
    input wire logic [1:0]            s_axi_bresp,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready,
    input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0]            s_axi_rresp,
    input wire logic                  sck_oe_o,
    input wire logic                  txd_oe_o,
    input wire logic [1:0]            bit_tick_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    reset_pins_off_a: assert property ($fell(srst_i) |->
        !sck_oe_o && !txd_oe_o && !s_axi_bvalid && !s_axi_rvalid)
        else $error("pins on");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("no read answer");
    write_busy_a: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write taken early");
    unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr[1:0] == 2'h0 && s_axi_araddr > OFS_STATUS
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
        else $error("unmapped");
    tick0_gap_a: assert property (bit_tick_o[0] |=>
        !bit_tick_o[0] [*3]) else $error("channel 0 tick too close");
    tick1_gap_a: assert property ($rose(bit_tick_o[1]) |=>
        !bit_tick_o[1] ##1 !bit_tick_o[1]) else $error("channel 1 tick");
endmodule

bind scpb_top scpb_checker i_scpb_checker (.ref_clk_i, .srst_i,
    .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .sck_oe_o, .txd_oe_o,
    .bit_tick_o);

// ---- bench/scpb_serial_peer.sv ----
// far-side serial device on the clock, transmit and receive pins
`timescale 1ns/1ns
module scpb_serial_peer (
    input  wire logic ref_clk_i,
    input  wire logic sck_o,
    input  wire logic sck_oe_o,
    input  wire logic txd_o,
    input  wire logic txd_oe_o,
    input  wire logic sck_level_i,
    input  wire logic rxd_level_i,
    output logic      sck_pin_o,
    output logic      rxd_o,
    output logic      txd_line_o
);
    logic txd_last;

    // released line shows the inverse, so a stale value never matches
    always_ff @(posedge ref_clk_i) if (txd_oe_o) txd_last <= txd_o;
    assign sck_pin_o  = sck_oe_o ? sck_o : sck_level_i;
    assign txd_line_o = txd_oe_o ? txd_o : ~txd_last;
    assign rxd_o      = rxd_level_i;
endmodule

// ---- bench/sci_port_and_bit_rate_test.sv ----
// self-checking bench for the serial port block
`timescale 1ns/1ns
module sci_port_and_bit_rate_test import scpb_pkg::*;;
    logic        ref_clk_i = 1'h0, srst_i = 1'h1;
    logic        standby_i = 1'h0, module_standby_i = 1'h0;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0, sck_lvl = 1'h0, rxd_lvl = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, sck_i, sck_o, sck_oe_o, txd_o, txd_oe_o;
    logic        rxd_i, txd_line;
    logic [1:0]  s_axi_bresp, s_axi_rresp, bit_tick_o;
    logic [33:0] exp_q[$], mask_q[$];
    logic [1:0]  bexp_q[$];
    int          bad_count = 0, cmp_count = 0, cycles = 0, seed = 61;
    logic [33:0] rst_exp [8] = '{34'h8, 34'h0, 34'hFF, 34'hFF, 34'h0, 34'h0,
                                 34'h0, 34'h2_0000_0000};

    always #10 ref_clk_i = ~ref_clk_i;

    scpb_top i_scpb_top (.ref_clk_i, .srst_i, .standby_i, .module_standby_i,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .sck_i, .sck_o, .sck_oe_o, .txd_o, .txd_oe_o, .rxd_i,
        .bit_tick_o);
    scpb_serial_peer i_scpb_serial_peer (.ref_clk_i, .sck_o, .sck_oe_o,
        .txd_o, .txd_oe_o, .sck_level_i(sck_lvl), .rxd_level_i(rxd_lvl),
        .sck_pin_o(sck_i), .rxd_o(rxd_i), .txd_line_o(txd_line));

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        logic aw_done, w_done;
        aw_done = 1'h0;
        w_done = 1'h0;
        bexp_q.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (!(aw_done && w_done)) begin
            @(posedge ref_clk_i);
            aw_done = aw_done | s_axi_awready;
            w_done = w_done | s_axi_wready;
            if (aw_done) s_axi_awvalid <= 1'h0;
            if (w_done) s_axi_wvalid <= 1'h0;
        end
        @(posedge ref_clk_i);
        s_axi_bready <= 1'h1;
        do @(posedge ref_clk_i); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        @(posedge ref_clk_i);
    endtask

    // mask hides bits whose value is not defined
    task automatic rd(input logic [7:0] a, input logic [33:0] e,
                      input logic [33:0] m);
        exp_q.push_back(e & m);
        mask_q.push_back(m);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge ref_clk_i); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        @(posedge ref_clk_i);
        s_axi_rready <= 1'h1;
        do @(posedge ref_clk_i); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        @(posedge ref_clk_i);
    endtask

    task automatic rate(input int ch, input int sy, input int ps, input int n);
        int cnt;
        wr(OFS_DIVISOR_0 + 8'(4 * ch), 32'(n), RESP_OKAY);
        wr(OFS_CHAN_CFG_0 + 8'(4 * ch), 32'(8 + 4 * sy + ps),
           RESP_OKAY);
        do @(posedge ref_clk_i); while (!bit_tick_o[ch]);
        cnt = 0;
        do begin
            @(posedge ref_clk_i);
            cnt++;
        end while (!bit_tick_o[ch]);
        check(34'(cnt), 34'((n + 1) * (sy ? 8 : 64) * 4**ps / 2));
        wr(OFS_CHAN_CFG_0 + 8'(4 * ch), 32'h0, RESP_OKAY);
    endtask

    always @(posedge ref_clk_i) begin
        if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rresp, s_axi_rdata} & mask_q.pop_front(),
                  exp_q.pop_front());
        if (s_axi_bvalid && s_axi_bready)
            check(34'(s_axi_bresp), 34'(bexp_q.pop_front()));
    end

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles > 60000) begin
            bad_count++;
            complete_run();
        end
    end

    initial begin
        logic [7:0] d0, d1;
        repeat (2) @(posedge ref_clk_i);
        srst_i <= 1'h0;
        for (int i = 0; i < 8; i++)
            rd(8'(4 * i), rst_exp[i], i == 1 ? ~34'h1 : '1);
        wr(8'h1C, 32'h1, RESP_SLVERR);
        d0 = 8'($random(seed));
        d1 = 8'($random(seed));
        wr(OFS_DIVISOR_0, 32'(d0), RESP_OKAY);
        wr(OFS_DIVISOR_1, 32'(d1), RESP_OKAY);
        rd(OFS_DIVISOR_0, 34'(d0), '1);
        rd(OFS_DIVISOR_1, 34'(d1), '1);
        for (int s = 0; s < 2; s++) begin
            wr(OFS_DIVISOR_1, 32'(d1), RESP_OKAY);
            {module_standby_i, standby_i} <= 2'(1 << s);
            repeat (2) @(posedge ref_clk_i);
            {module_standby_i, standby_i} <= 2'h0;
            @(posedge ref_clk_i);
            rd(OFS_DIVISOR_1, 34'hFF, '1);
        end
        // transmit and receive enables stay clear during port use
        for (int m = 0; m < 4; m++) begin
            for (int b = 0; b < 2; b++) begin
                sck_lvl <= 1'(b);
                wr(OFS_PIN_CONTROL, 32'(5 * m), RESP_OKAY);
                wr(OFS_PIN_DATA, 32'(b ? 1 : 2), RESP_OKAY);
                check(34'({sck_oe_o, txd_oe_o}),
                      34'({2{m == 1}}));
                if (m == 1)
                    check(34'({sck_o, txd_line}), 34'(2 - b));
                if (m >= 2)
                    rd(OFS_PIN_DATA, 34'(2 * b), 34'h2);
            end
        end
        wr(OFS_CHAN_CFG_0, 32'h10, RESP_OKAY);
        for (int r = 0; r < 2; r++) begin
            rxd_lvl <= 1'(r);
            wr(OFS_PIN_DATA, 32'(1 - r), RESP_OKAY);
            rd(OFS_PIN_DATA, 34'(r), 34'h1);
        end
        wr(OFS_CHAN_CFG_0, 32'h0, RESP_OKAY);
        for (int p = 0; p < 4; p++) begin
            rate(0, 0, p, p == 0 ? 0 : $random(seed) & 3);
            rate(1, 1, p, p == 0 ? 255 : $random(seed) & 7);
        end
        complete_run();
    end
endmodule
